/* mcw_pkg.sv */
// package of constants and types for the modem calibration and watchdog block
package mcw_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned LS_PTT_LIMIT_S = 150;
  localparam int unsigned HS_PTT_LIMIT_S = 30;
  localparam longint LS_PTT_CYC = longint'(LS_PTT_LIMIT_S) * CLK_HZ;
  localparam longint HS_PTT_CYC = longint'(HS_PTT_LIMIT_S) * CLK_HZ;
  localparam int unsigned CPU_WDOG_MS = 1000;
  localparam longint CPU_WDOG_CYC = longint'(CPU_WDOG_MS) * (CLK_HZ / 1000);
  localparam int unsigned RESET_PULSE_CYC = 16;
  localparam logic [7:0] LS_LEVEL_RST = 8'h64;
  localparam logic [7:0] HS_LEVEL_RST = 8'h40;
  localparam logic [7:0] EQ_RST = 8'h80;
  localparam logic [7:0] LEVEL_MAX = 8'hFF;
  localparam logic [7:0] LEVEL_MIN = 8'h00;
  localparam logic [7:0] CH_M = 8'h4D;
  localparam logic [7:0] CH_R = 8'h52;
  localparam logic [7:0] CH_S = 8'h53;
  localparam logic [7:0] CH_T = 8'h54;
  localparam logic [7:0] CH_X = 8'h58;
  localparam logic [7:0] CH_MINUS = 8'h2D;
  localparam logic [7:0] CH_PLUS = 8'h2B;
  localparam logic [7:0] CH_LT = 8'h3C;
  localparam logic [7:0] CH_GT = 8'h3E;
  // register offsets (byte addresses)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_LEVEL = 4'h8;
  localparam logic [3:0] REG_MEAS = 4'hC;
  // control field positions
  localparam int CTRL_CAL_BIT = 0;
  localparam int CTRL_HSSEL_BIT = 1;
  localparam int CTRL_EQLOAD_BIT = 2;
  localparam int CTRL_KICK_BIT = 3;
  localparam int CTRL_EQ_LSB = 8;
  typedef enum logic [2:0] {
    TX_IDLE  = 3'b000,
    TX_MARK  = 3'b001,
    TX_SPACE = 3'b010,
    TX_SQ    = 3'b011,
    TX_SCRAM = 3'b100
  } mcw_tx_t;
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } mcw_char_t;
  typedef struct packed {
    logic [15:0] spaceCnt;
    logic [15:0] markCnt;
  } mcw_meas_t;
endpackage

/* mcw_top.sv */
// calibration command interpreter, push-to-talk and processor watchdogs
//
// Added by the designer: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module mcw_top #(
  parameter longint LS_PTT_CYCLES = mcw_pkg::LS_PTT_CYC,
  parameter longint HS_PTT_CYCLES = mcw_pkg::HS_PTT_CYC,
  parameter longint CPU_WDOG_CYCLES = mcw_pkg::CPU_WDOG_CYC,
  parameter int     SQ_HALF_CYCLES = 2604
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire mcw_pkg::mcw_char_t hostChar,
  input  wire logic [3:0]        address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [31:0]       writedata,
  output logic [31:0]            readdata,
  output logic                   waitrequest,
  input  wire logic              lsPttReq,
  input  wire logic              hsPttReq,
  input  wire logic              lsWdogStrapPin,
  input  wire logic              hsWdogStrapPin,
  input  wire logic              rxTonePin,
  input  wire logic              sigQualityPin,
  input  wire logic [7:0]        analog0,
  input  wire logic [7:0]        analog1,
  output logic                   lsPttOut,
  output logic                   hsPttOut,
  output logic                   lsToneMark,
  output logic                   lsToneOn,
  output logic                   hsTxData,
  output logic                   hsTxOn,
  output logic [7:0]             lsLevel,
  output logic [7:0]             hsLevel,
  output logic [7:0]             eqSetting,
  output logic                   statusLed,
  output logic                   unitReset
);
  // ************************************************************
  // input synchronisers
  // ************************************************************
  logic [3:0] syncA_r, syncB_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA_r <= 4'h0;
      syncB_r <= 4'h0;
    end else begin
      syncA_r <= {lsWdogStrapPin, hsWdogStrapPin, rxTonePin,
                  sigQualityPin};
      syncB_r <= syncA_r;
    end
  end
  logic lsStrap, hsStrap, rxTone, sigQ;
  assign lsStrap = syncB_r[3];
  assign hsStrap = syncB_r[2];
  assign rxTone  = syncB_r[1];
  assign sigQ    = syncB_r[0];

  // saturating one-step adjust shared by level and equalization counts
  function automatic logic [7:0] stepSat(input logic [7:0] v,
                                         input logic up, input logic dn);
    if (up && v != mcw_pkg::LEVEL_MAX)
      stepSat = v + 8'h01;
    else if (dn && v != mcw_pkg::LEVEL_MIN)
      stepSat = v - 8'h01;
    else
      stepSat = v;
  endfunction

  // ************************************************************
  // register bus and command interpreter state
  // ************************************************************
  logic        calOn_r, calOn_nxt;
  logic        hsSel_r, hsSel_nxt;
  mcw_pkg::mcw_tx_t txMode_r, txMode_nxt;
  logic [7:0]  lsLvl_r, lsLvl_nxt, hsLvl_r, hsLvl_nxt, eq_r, eq_nxt;
  logic        measReq_r, measReq_nxt;
  logic        kick_r, kick_nxt;
  logic        xReset_r, xReset_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        rdValid_r, rdValid_nxt;
  mcw_pkg::mcw_meas_t meas_r;
  logic        measDone_r;
  logic [7:0]  ch;
  logic        txActive;

  // reads take one wait state so that readdata comes from a flip-flop
  // and already stands at the edge where waitrequest is seen low
  assign waitrequest = read && !rdValid_r;
  assign ch = hostChar.data;
  assign txActive = (txMode_r != mcw_pkg::TX_IDLE);

  always_comb begin
    calOn_nxt = calOn_r;
    hsSel_nxt = hsSel_r;
    txMode_nxt = txMode_r;
    lsLvl_nxt = lsLvl_r;
    hsLvl_nxt = hsLvl_r;
    eq_nxt = eq_r;
    measReq_nxt = 1'b0;
    kick_nxt = 1'b0;
    xReset_nxt = 1'b0;
    rdata_nxt = rdata_r;
    rdValid_nxt = read && !rdValid_r;
    if (write) begin
      unique case (address)
        mcw_pkg::REG_CTRL: begin
          calOn_nxt = writedata[mcw_pkg::CTRL_CAL_BIT];
          hsSel_nxt = writedata[mcw_pkg::CTRL_HSSEL_BIT];
          kick_nxt = writedata[mcw_pkg::CTRL_KICK_BIT];
          if (writedata[mcw_pkg::CTRL_EQLOAD_BIT])
            eq_nxt = writedata[mcw_pkg::CTRL_EQ_LSB +: 8];
          if (!writedata[mcw_pkg::CTRL_CAL_BIT])
            txMode_nxt = mcw_pkg::TX_IDLE;
        end
        mcw_pkg::REG_LEVEL: begin
          lsLvl_nxt = writedata[7:0];
          hsLvl_nxt = writedata[15:8];
        end
        default: begin
        end
      endcase
    end
    if (read && !rdValid_r) begin
      unique case (address)
        mcw_pkg::REG_CTRL:
          rdata_nxt = {16'h0000, eq_r, 4'h0, 1'b0, 1'b0, hsSel_r, calOn_r};
        mcw_pkg::REG_STATUS:
          rdata_nxt = {analog1, analog0, 8'h00, measDone_r,
                       sigQ, hsStrap, lsStrap, txMode_r, calOn_r};
        mcw_pkg::REG_LEVEL:
          rdata_nxt = {16'h0000, hsLvl_r, lsLvl_r};
        mcw_pkg::REG_MEAS:
          rdata_nxt = meas_r;
        default:
          rdata_nxt = 32'h0000_0000;
      endcase
    end
    // any key stops a running test signal, adjust keys keep it going;
    // a keystroke wins over a bus write in the same cycle
    if (calOn_r && hostChar.valid) begin
      txMode_nxt = mcw_pkg::TX_IDLE;
      if (!hsSel_r) begin
        unique case (ch)
          mcw_pkg::CH_M: txMode_nxt = mcw_pkg::TX_MARK;
          mcw_pkg::CH_S: txMode_nxt = mcw_pkg::TX_SPACE;
          mcw_pkg::CH_T: txMode_nxt = mcw_pkg::TX_SQ;
          mcw_pkg::CH_R: measReq_nxt = 1'b1;
          mcw_pkg::CH_X: begin
            calOn_nxt = 1'b0;
            xReset_nxt = 1'b1;
          end
          mcw_pkg::CH_MINUS, mcw_pkg::CH_PLUS: begin
            txMode_nxt = txMode_r;
            if (txActive)
              lsLvl_nxt = stepSat(lsLvl_r, ch == mcw_pkg::CH_PLUS,
                                  ch == mcw_pkg::CH_MINUS);
          end
          default: begin
          end
        endcase
      end else begin
        unique case (ch)
          mcw_pkg::CH_S: txMode_nxt = mcw_pkg::TX_SCRAM;
          mcw_pkg::CH_T: txMode_nxt = mcw_pkg::TX_SQ;
          mcw_pkg::CH_X: calOn_nxt = 1'b0;
          mcw_pkg::CH_LT, mcw_pkg::CH_GT: begin
            txMode_nxt = txMode_r;
            eq_nxt = stepSat(eq_r, ch == mcw_pkg::CH_GT,
                             ch == mcw_pkg::CH_LT);
          end
          mcw_pkg::CH_MINUS, mcw_pkg::CH_PLUS: begin
            txMode_nxt = txMode_r;
            if (txActive)
              hsLvl_nxt = stepSat(hsLvl_r, ch == mcw_pkg::CH_PLUS,
                                  ch == mcw_pkg::CH_MINUS);
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      calOn_r <= 1'b0;
      hsSel_r <= 1'b0;
      txMode_r <= mcw_pkg::TX_IDLE;
      lsLvl_r <= mcw_pkg::LS_LEVEL_RST;
      hsLvl_r <= mcw_pkg::HS_LEVEL_RST;
      eq_r <= mcw_pkg::EQ_RST;
      measReq_r <= 1'b0;
      kick_r <= 1'b0;
      xReset_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rdValid_r <= 1'b0;
    end else begin
      calOn_r <= calOn_nxt;
      hsSel_r <= hsSel_nxt;
      txMode_r <= txMode_nxt;
      lsLvl_r <= lsLvl_nxt;
      hsLvl_r <= hsLvl_nxt;
      eq_r <= eq_nxt;
      measReq_r <= measReq_nxt;
      kick_r <= kick_nxt;
      xReset_r <= xReset_nxt;
      rdata_r <= rdata_nxt;
      rdValid_r <= rdValid_nxt;
    end
  end
  assign readdata = rdata_r;

  // ************************************************************
  // test signal generators
  // ************************************************************
  logic [15:0] sqCnt_r, sqCnt_nxt;
  logic        sqPh_r, sqPh_nxt;
  logic [14:0] lfsr_r, lfsr_nxt;
  // half-period counter also paces the scrambler, one rate for both
  always_comb begin
    sqPh_nxt = sqPh_r;
    lfsr_nxt = lfsr_r;
    sqCnt_nxt = sqCnt_r + 16'h0001;
    if (sqCnt_r == 16'(SQ_HALF_CYCLES - 1)) begin
      sqCnt_nxt = 16'h0000;
      sqPh_nxt = ~sqPh_r;
      lfsr_nxt = {lfsr_r[13:0], lfsr_r[14] ^ lfsr_r[13]};
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sqCnt_r <= 16'h0000;
      sqPh_r <= 1'b0;
      lfsr_r <= 15'h0001;
    end else begin
      sqCnt_r <= sqCnt_nxt;
      sqPh_r <= sqPh_nxt;
      lfsr_r <= lfsr_nxt;
    end
  end
  logic lsTx, hsTx;
  assign lsTx = txActive && !hsSel_r;
  assign hsTx = txActive && hsSel_r;

  // ************************************************************
  // received square wave measurement
  // ************************************************************
  logic        measBusy_r, measBusy_nxt, measDone_nxt, rxPrev_r;
  logic [1:0]  edges_r, edges_nxt;
  mcw_pkg::mcw_meas_t meas_nxt;
  // window opens at the first rising rx edge and closes at the next,
  // so exactly one received period is split into mark and space
  always_comb begin
    measBusy_nxt = measBusy_r;
    edges_nxt = edges_r;
    meas_nxt = meas_r;
    measDone_nxt = measDone_r;
    if (measReq_r) begin
      measBusy_nxt = 1'b1;
      measDone_nxt = 1'b0;
      edges_nxt = 2'b00;
      meas_nxt = '0;
    end else if (measBusy_r) begin
      if (rxTone && !rxPrev_r)
        edges_nxt = edges_r + 2'b01;
      if (edges_r == 2'b01) begin
        if (rxTone)
          meas_nxt.markCnt = meas_r.markCnt + 16'h0001;
        else
          meas_nxt.spaceCnt = meas_r.spaceCnt + 16'h0001;
      end
      if (edges_r == 2'b10) begin
        measBusy_nxt = 1'b0;
        measDone_nxt = 1'b1;
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      measBusy_r <= 1'b0;
      measDone_r <= 1'b0;
      edges_r <= 2'b00;
      meas_r <= '0;
      rxPrev_r <= 1'b0;
    end else begin
      measBusy_r <= measBusy_nxt;
      measDone_r <= measDone_nxt;
      edges_r <= edges_nxt;
      meas_r <= meas_nxt;
      rxPrev_r <= rxTone;
    end
  end

  // ************************************************************
  // push-to-talk and processor watchdogs
  // ************************************************************
  logic [32:0] lsCnt_r, lsCnt_nxt, hsCnt_r, hsCnt_nxt, cpuCnt_r, cpuCnt_nxt;
  logic        lsTrip_r, lsTrip_nxt, hsTrip_r, hsTrip_nxt;
  logic [4:0]  rstCnt_r, rstCnt_nxt;
  logic        lsKey, hsKey;
  assign lsKey = lsPttReq || lsTx;
  assign hsKey = hsPttReq || hsTx;
  // counters clear whenever the key drops, so only continuous keying trips;
  // a trip keeps the key released until the request goes away
  always_comb begin
    lsCnt_nxt = 33'h0_0000_0000;
    hsCnt_nxt = 33'h0_0000_0000;
    lsTrip_nxt = 1'b0;
    hsTrip_nxt = 1'b0;
    if (lsKey && !lsStrap) begin
      lsTrip_nxt = lsTrip_r || (lsCnt_r == 33'(LS_PTT_CYCLES));
      lsCnt_nxt = lsTrip_nxt ? lsCnt_r : lsCnt_r + 33'h0_0000_0001;
    end
    if (hsKey && !hsStrap) begin
      hsTrip_nxt = hsTrip_r || (hsCnt_r == 33'(HS_PTT_CYCLES));
      hsCnt_nxt = hsTrip_nxt ? hsCnt_r : hsCnt_r + 33'h0_0000_0001;
    end
    cpuCnt_nxt = kick_r ? 33'h0_0000_0000 : cpuCnt_r + 33'h0_0000_0001;
    // a new cause during a pulse restarts the pulse
    rstCnt_nxt = (rstCnt_r != 5'h00) ? rstCnt_r - 5'h01 : 5'h00;
    if (cpuCnt_r == 33'(CPU_WDOG_CYCLES) || xReset_r) begin
      cpuCnt_nxt = 33'h0_0000_0000;
      rstCnt_nxt = 5'(mcw_pkg::RESET_PULSE_CYC);
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lsCnt_r <= 33'h0_0000_0000;
      hsCnt_r <= 33'h0_0000_0000;
      cpuCnt_r <= 33'h0_0000_0000;
      lsTrip_r <= 1'b0;
      hsTrip_r <= 1'b0;
      rstCnt_r <= 5'h00;
    end else begin
      lsCnt_r <= lsCnt_nxt;
      hsCnt_r <= hsCnt_nxt;
      cpuCnt_r <= cpuCnt_nxt;
      lsTrip_r <= lsTrip_nxt;
      hsTrip_r <= hsTrip_nxt;
      rstCnt_r <= rstCnt_nxt;
    end
  end

  // ************************************************************
  // registered outputs
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lsPttOut <= 1'b0;
      hsPttOut <= 1'b0;
      lsToneOn <= 1'b0;
      lsToneMark <= 1'b0;
      hsTxOn <= 1'b0;
      hsTxData <= 1'b0;
      statusLed <= 1'b0;
      unitReset <= 1'b0;
    end else begin
      // next trip value used so the cut lands on the limit edge
      lsPttOut <= lsKey && !lsTrip_nxt;
      hsPttOut <= hsKey && !hsTrip_nxt;
      lsToneOn <= lsTx;
      lsToneMark <= (txMode_r == mcw_pkg::TX_MARK) ||
                    (txMode_r == mcw_pkg::TX_SQ && sqPh_r);
      hsTxOn <= hsTx;
      hsTxData <= (txMode_r == mcw_pkg::TX_SCRAM) ? lfsr_r[0] : sqPh_r;
      statusLed <= sigQ;
      unitReset <= (rstCnt_r != 5'h00);
    end
  end
  assign lsLevel = lsLvl_r;
  assign hsLevel = hsLvl_r;
  assign eqSetting = eq_r;
endmodule
`default_nettype wire

/* mcw_sva.sv */
// assertion checker for the calibration and watchdog block
`timescale 1ns/1ps
`default_nettype none
module mcw_sva #(
  parameter longint LS_PTT_CYCLES   = 50,
  parameter longint HS_PTT_CYCLES   = 30,
  parameter longint CPU_WDOG_CYCLES = 200
) (
  input wire logic               clk,
  input wire logic               rst_n,
  input wire mcw_pkg::mcw_char_t hostChar,
  input wire logic [3:0]         address,
  input wire logic               write,
  input wire logic [31:0]        writedata,
  input wire logic               hsPttReq,
  input wire logic               lsWdogStrapPin,
  input wire logic               hsWdogStrapPin,
  input wire logic               sigQualityPin,
  input wire logic               lsPttOut,
  input wire logic               hsPttOut,
  input wire logic               lsToneOn,
  input wire logic               hsTxOn,
  input wire logic [7:0]         lsLevel,
  input wire logic [7:0]         hsLevel,
  input wire logic [7:0]         eqSetting,
  input wire logic               statusLed,
  input wire logic               unitReset
);
  logic [31:0] lsCnt_r, hsCnt_r, pulseCnt_r, idleCnt_r;
  logic [31:0] lsCnt_nxt, hsCnt_nxt, pulseCnt_nxt, idleCnt_nxt;
  logic        kick;
  always_comb begin
    kick = write && address == mcw_pkg::REG_CTRL
           && writedata[mcw_pkg::CTRL_KICK_BIT];
    lsCnt_nxt = (lsPttOut && !lsWdogStrapPin) ? lsCnt_r + 32'h1 : 32'h0;
    hsCnt_nxt = (hsPttOut && !hsWdogStrapPin) ? hsCnt_r + 32'h1 : 32'h0;
    pulseCnt_nxt = unitReset ? pulseCnt_r + 32'h1 : 32'h0;
    idleCnt_nxt = (unitReset || kick) ? 32'h0 : idleCnt_r + 32'h1;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lsCnt_r    <= 32'h0;
      hsCnt_r    <= 32'h0;
      pulseCnt_r <= 32'h0;
      idleCnt_r  <= 32'h0;
    end else begin
      lsCnt_r    <= lsCnt_nxt;
      hsCnt_r    <= hsCnt_nxt;
      pulseCnt_r <= pulseCnt_nxt;
      idleCnt_r  <= idleCnt_nxt;
    end
  end
  //****************************************
  // properties
  //****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_level_init: assert property ($rose(rst_n) |-> lsLevel == 8'h64
    && hsLevel == 8'h40 && eqSetting == 8'h80) else $error("bad reset level");
  a_ls_step: assert property ($changed(lsLevel) && !$past(write)
    && !$past(write, 2) |-> lsLevel == $past(lsLevel) + 8'h1
    || lsLevel == $past(lsLevel) - 8'h1) else $error("level jumped");
  a_eq_step: assert property ($changed(eqSetting) && !$past(write)
    && !$past(write, 2) |-> eqSetting == $past(eqSetting) + 8'h1
    || eqSetting == $past(eqSetting) - 8'h1) else $error("eq jumped");
  a_ls_ptt_cut: assert property (lsCnt_r <= LS_PTT_CYCLES + 3)
    else $error("low-speed key held too long");
  a_hs_ptt_cut: assert property (hsCnt_r <= HS_PTT_CYCLES + 3)
    else $error("high-speed key held too long");
  a_ptt_cause: assert property ($rose(hsPttOut) |-> $past(hsPttReq)
    || hsTxOn || $past(hsTxOn)) else $error("key without cause");
  a_exit_quiet: assert property (hostChar.valid && hostChar.data == 8'h58
    |-> ##3 (!lsToneOn && !hsTxOn)[*2]) else $error("tone after exit");
  a_pulse_len: assert property ($fell(unitReset) |-> pulseCnt_r == 32'h10)
    else $error("reset pulse length");
  a_led_follow: assert property (sigQualityPin[*5] |=> statusLed)
    else $error("led not lit");
  a_cpu_wdog: assert property (idleCnt_r <= CPU_WDOG_CYCLES + 8)
    else $error("watchdog did not fire");
endmodule
bind mcw_top mcw_sva #(.LS_PTT_CYCLES(LS_PTT_CYCLES),
  .HS_PTT_CYCLES(HS_PTT_CYCLES), .CPU_WDOG_CYCLES(CPU_WDOG_CYCLES))
  mcw_sva_inst (.clk(clk), .rst_n(rst_n), .hostChar(hostChar),
  .address(address), .write(write), .writedata(writedata),
  .hsPttReq(hsPttReq), .lsWdogStrapPin(lsWdogStrapPin),
  .hsWdogStrapPin(hsWdogStrapPin), .sigQualityPin(sigQualityPin),
  .lsPttOut(lsPttOut), .hsPttOut(hsPttOut), .lsToneOn(lsToneOn),
  .hsTxOn(hsTxOn), .lsLevel(lsLevel), .hsLevel(hsLevel),
  .eqSetting(eqSetting), .statusLed(statusLed), .unitReset(unitReset));
`default_nettype wire

/* mcw_far_end.sv */
// terminal keystrokes and far-station test tone for the bench
`timescale 1ns/1ps
`default_nettype none
module mcw_far_end (
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               keyStb,
  input  wire logic [7:0]         keyCode,
  input  wire logic               toneEn,
  input  wire logic [7:0]         markLen,
  input  wire logic [7:0]         spaceLen,
  output var  mcw_pkg::mcw_char_t hostChar,
  output var  logic               rxTonePin
);
  mcw_pkg::mcw_char_t hostChar_nxt;
  logic [7:0]         cnt_r;
  logic [7:0]         cnt_nxt;
  logic               tone_nxt;
  // data between keystrokes changes every cycle so stale bytes are not trusted
  always_comb begin
    hostChar_nxt.valid = keyStb;
    hostChar_nxt.data  = keyStb ? keyCode : ~hostChar.data;
    cnt_nxt  = cnt_r + 8'h01;
    tone_nxt = rxTonePin;
    if (!toneEn) begin
      cnt_nxt  = 8'h00;
      tone_nxt = 1'b1;
    end else if (cnt_nxt == (rxTonePin ? markLen : spaceLen)) begin
      cnt_nxt  = 8'h00;
      tone_nxt = !rxTonePin;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hostChar  <= '0;
      cnt_r     <= 8'h00;
      rxTonePin <= 1'b1;
    end else begin
      hostChar  <= hostChar_nxt;
      cnt_r     <= cnt_nxt;
      rxTonePin <= tone_nxt;
    end
  end
endmodule
`default_nettype wire

/* testbench.sv */
// self-checking bench for the calibration and watchdog block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int SQH = 4;
  logic               clk = 1'b0;
  logic               rst_n = 1'b0;
  logic               keyStb = 1'b0;
  logic [7:0]         keyCode = 8'h00;
  logic               toneEn = 1'b0;
  mcw_pkg::mcw_char_t hostChar;
  logic [3:0]         address = 4'h0;
  logic               read = 1'b0;
  logic               write = 1'b0;
  logic [31:0]        writedata = 32'h0;
  logic [31:0]        readdata, d;
  logic [1:0]         pttReq = 2'h0;
  logic [1:0]         strap = 2'h0;
  logic [1:0]         pttOut;
  logic               sigQ = 1'b0;
  logic               waitrequest, rxTonePin, lsToneMark, lsToneOn, hsTxData;
  logic               hsTxOn, statusLed, unitReset;
  logic [7:0]         lsLevel, hsLevel, eqSetting;
  logic [7:0]         an0 = 8'hA5;
  logic [7:0]         an1 = 8'h3C;
  int                 errTotal = 0;
  int                 cmpCount = 0;
  int                 cycles = 0;
  always #10 clk = ~clk;
  mcw_top #(.LS_PTT_CYCLES(50), .HS_PTT_CYCLES(30), .CPU_WDOG_CYCLES(200),
    .SQ_HALF_CYCLES(SQH)) mcw_top_inst (.clk(clk), .rst_n(rst_n),
    .hostChar(hostChar), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .lsPttReq(pttReq[0]), .hsPttReq(pttReq[1]), .lsWdogStrapPin(strap[0]),
    .hsWdogStrapPin(strap[1]), .rxTonePin(rxTonePin), .sigQualityPin(sigQ),
    .analog0(an0), .analog1(an1), .lsPttOut(pttOut[0]),
    .hsPttOut(pttOut[1]), .lsToneMark(lsToneMark), .lsToneOn(lsToneOn),
    .hsTxData(hsTxData), .hsTxOn(hsTxOn), .lsLevel(lsLevel),
    .hsLevel(hsLevel), .eqSetting(eqSetting), .statusLed(statusLed),
    .unitReset(unitReset));
  mcw_far_end mcw_far_end_inst (.clk(clk), .rst_n(rst_n), .keyStb(keyStb),
    .keyCode(keyCode), .toneEn(toneEn), .markLen(8'h06), .spaceLen(8'h04),
    .hostChar(hostChar), .rxTonePin(rxTonePin));
  //****************************************
  // shared tasks
  //****************************************
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmpCount, errTotal);
    if (errTotal == 0 && cmpCount > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errTotal++;
      summarize;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      errTotal++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic busWr(input logic [3:0] a, input logic [31:0] v);
    address <= a;
    writedata <= v;
    write <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic busRd(input logic [3:0] a);
    address <= a;
    read <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    d = readdata;
    read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic key(input logic [7:0] c);
    keyCode <= c;
    keyStb <= 1'b1;
    @(posedge clk);
    keyStb <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic waitPulse(input int n, output logic seen);
    seen = 1'b0;
    repeat (n) begin
      @(posedge clk);
      if (unitReset === 1'b1) seen = 1'b1;
    end
  endtask
  //****************************************
  // scenarios
  //****************************************
  task automatic t_reset;
    check(32'({lsLevel, hsLevel, eqSetting}), 32'h0064_4080);
    busRd(mcw_pkg::REG_LEVEL);
    check(d, 32'h0000_4064);
    busRd(4'h1);
    check(d, 32'h0);
  endtask
  task automatic t_ls;
    logic hi, lo;
    busWr(mcw_pkg::REG_LEVEL, 32'h0000_00FF);
    busWr(mcw_pkg::REG_CTRL, 32'h0000_0009);
    key(mcw_pkg::CH_M);
    check(32'({lsToneOn, lsToneMark}), 32'h3);
    key(mcw_pkg::CH_S);
    busRd(mcw_pkg::REG_STATUS);
    check(32'({lsToneOn, lsToneMark, d[3:0]}), 32'h25);
    key(mcw_pkg::CH_T);
    hi = 1'b0;
    lo = 1'b0;
    repeat (4 * SQH) begin
      @(posedge clk);
      if (lsToneMark === 1'b1) hi = 1'b1;
      if (lsToneMark === 1'b0) lo = 1'b1;
    end
    check(32'({lsToneOn, hi, lo}), 32'h7);
    key(mcw_pkg::CH_PLUS);
    check(32'(lsLevel), 32'hFF);
    key(mcw_pkg::CH_MINUS);
    key(mcw_pkg::CH_MINUS);
    check(32'({lsToneOn, lsLevel}), 32'h1FD);
    toneEn <= 1'b1;
    key(mcw_pkg::CH_R);
    key(mcw_pkg::CH_PLUS);
    check(32'({lsToneOn, lsLevel}), 32'h0FD);
    repeat (30) @(posedge clk);
    busRd(mcw_pkg::REG_MEAS);
    check(d, 32'h0004_0006);
    busRd(mcw_pkg::REG_STATUS);
    check(32'(d[7]), 32'h1);
    busWr(mcw_pkg::REG_CTRL, 32'h0000_0009);
    key(mcw_pkg::CH_X);
    waitPulse(8, hi);
    busRd(mcw_pkg::REG_STATUS);
    check(32'({hi, d[0]}), 32'h2);
  endtask
  task automatic t_hs;
    logic hi, lo;
    busWr(mcw_pkg::REG_LEVEL, 32'h0000_00FF);
    busWr(mcw_pkg::REG_CTRL, 32'h0000_100F);
    check(32'(eqSetting), 32'h10);
    key(mcw_pkg::CH_M);
    check(32'({lsToneOn, hsTxOn}), 32'h0);
    key(mcw_pkg::CH_S);
    busRd(mcw_pkg::REG_STATUS);
    check(32'({hsTxOn, d[3:0]}), 32'h19);
    key(mcw_pkg::CH_MINUS);
    check(32'(hsLevel), 32'h0);
    key(mcw_pkg::CH_PLUS);
    check(32'(hsLevel), 32'h1);
    key(mcw_pkg::CH_T);
    busRd(mcw_pkg::REG_STATUS);
    check(32'({hsTxOn, d[3:0]}), 32'h17);
    hi = 1'b0;
    lo = 1'b0;
    repeat (4 * SQH) begin
      @(posedge clk);
      if (hsTxData === 1'b1) hi = 1'b1;
      if (hsTxData === 1'b0) lo = 1'b1;
    end
    check(32'({hi, lo}), 32'h3);
    key(mcw_pkg::CH_LT);
    check(32'(eqSetting), 32'h0F);
    key(mcw_pkg::CH_GT);
    key(mcw_pkg::CH_GT);
    check(32'({hsTxOn, eqSetting}), 32'h111);
    busWr(mcw_pkg::REG_CTRL, 32'h0000_000B);
    key(mcw_pkg::CH_X);
    waitPulse(20, hi);
    busRd(mcw_pkg::REG_STATUS);
    check(32'({hi, hsTxOn, d[0]}), 32'h0);
  endtask
  task automatic t_ptt(input int p, input int lim);
    pttReq[p] <= 1'b1;
    repeat (4) @(posedge clk);
    check(32'(pttOut[p]), 32'h1);
    repeat (lim) @(posedge clk);
    check(32'(pttOut[p]), 32'h0);
    pttReq[p] <= 1'b0;
    repeat (3) @(posedge clk);
    strap[p] <= 1'b1;
    pttReq[p] <= 1'b1;
    repeat (lim + 10) @(posedge clk);
    check(32'(pttOut[p]), 32'h1);
    pttReq[p] <= 1'b0;
    strap[p] <= 1'b0;
    @(posedge clk);
  endtask
  task automatic t_misc;
    logic hi;
    sigQ <= 1'b1;
    repeat (6) @(posedge clk);
    busRd(mcw_pkg::REG_STATUS);
    check(32'(d[31:16]), 32'h3CA5);
    check(32'({d[6], statusLed}), 32'h3);
    sigQ <= 1'b0;
    an0 <= 8'h00;
    an1 <= 8'hFF;
    repeat (6) @(posedge clk);
    check(32'(statusLed), 32'h0);
    busRd(mcw_pkg::REG_STATUS);
    check(32'({d[31:16], d[6]}), 32'h1FE00);
    waitPulse(260, hi);
    check(32'(hi), 32'h1);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset;
    t_ls;
    t_hs;
    t_ptt(0, 50);
    t_ptt(1, 30);
    t_misc;
    summarize;
  end
endmodule
`default_nettype wire
